// ==== design/opbc_bank_prog.sv ====
// one bank's program-and-verify sequencer
module opbc_bank_prog #(
	parameter int unsigned PULSE_CYC = opbc_pkg::PULSE_CYCLES,
	parameter int unsigned PULSE_FAST_CYC = opbc_pkg::PULSE_FAST_CYCLES,
	parameter int unsigned SETTLE_CYC = opbc_pkg::SETTLE_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request
	input wire logic start_i,
	input wire logic enable_i,
	input wire logic target_i,
	input wire logic fast_i,
	// synchronised readback of the selected cell bit
	input wire logic cell_bit_i,
	// results
	output logic busy_o,
	output logic error_o,
	output logic prog_o
);
	import opbc_pkg::*;

	// refuse empty counts, and normal pulse or settle counts the counter cannot hold
	if (PULSE_CYC < 1 || PULSE_FAST_CYC < 1 || SETTLE_CYC < 3 ||
		PULSE_CYC >= (1 << CNT_W) || SETTLE_CYC >= (1 << CNT_W)) begin
		$error("opbc_bank_prog: cycle count out of range");
	end

	typedef struct packed {
		opbc_bank_state_t state;
		logic [CNT_W-1:0] cnt;
		logic target;
		logic err;
		logic prog;
	} opbc_bank_st_t;

	opbc_bank_st_t cur_ff; // registered state
	opbc_bank_st_t nxt_cur; // next state

	// sequencer: an enabled bank pulses only when a one is wanted, then always verifies
	always_comb begin
		nxt_cur = cur_ff;
		case (cur_ff.state)
			BK_IDLE: begin
				if (start_i) begin
					// a new request clears the old verdict
					nxt_cur.err = 1'b0;
					nxt_cur.target = target_i;
					if (!enable_i) begin
						// disabled bank is left untouched
						nxt_cur.state = BK_IDLE;
					end else if (target_i) begin
						nxt_cur.state = BK_PULSE;
						nxt_cur.prog = 1'b1;
						nxt_cur.cnt = fast_i ? CNT_W'(PULSE_FAST_CYC - 1)
							: CNT_W'(PULSE_CYC - 1);
					end else begin
						// a zero cannot be burnt: verify only
						nxt_cur.state = BK_SETTLE;
						nxt_cur.cnt = CNT_W'(SETTLE_CYC - 1);
					end
				end
			end
			BK_PULSE: begin
				if (cur_ff.cnt == '0) begin
					nxt_cur.prog = 1'b0;
					nxt_cur.state = BK_SETTLE;
					nxt_cur.cnt = CNT_W'(SETTLE_CYC - 1);
				end else begin
					nxt_cur.cnt = cur_ff.cnt - 1'b1;
				end
			end
			BK_SETTLE: begin
				// waits out cell settling and the readback synchroniser
				if (cur_ff.cnt == '0) begin
					nxt_cur.state = BK_CHECK;
				end else begin
					nxt_cur.cnt = cur_ff.cnt - 1'b1;
				end
			end
			BK_CHECK: begin
				// bit must hold the target once the sequence ends
				nxt_cur.err = (cell_bit_i != cur_ff.target);
				nxt_cur.state = BK_IDLE;
			end
			default: begin
				nxt_cur.state = BK_IDLE;
				nxt_cur.prog = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_ff <= '{state: BK_IDLE, cnt: '0, target: 1'b0,
				err: 1'b0, prog: 1'b0};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign busy_o = (cur_ff.state != BK_IDLE);
	assign error_o = cur_ff.err;
	assign prog_o = cur_ff.prog;

endmodule

// ==== design/opbc_bitprog.sv ====
// Design decision made here: the address-and-strobe port.
module opbc_bitprog (
	// clock and reset
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// register port
	input wire logic [31:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	// state reported by the rest of the controller
	input wire logic [opbc_pkg::WADDR_W-1:0] WORDS_REMAINING_I,
	input wire logic [opbc_pkg::FIFO_CNT_W-1:0] FIFO_WORD_COUNT_I,
	input wire logic TEST_ERR_UPPER_I,
	input wire logic TEST_ERR_LOWER_I,
	input wire logic TEST_ERROR_SUMMARY_I,
	input wire logic TEST_READY_I,
	// upper macrocell bank
	output logic [opbc_pkg::WADDR_W:0] CELL_UPPER_ADDR_O,
	output logic [2:0] CELL_UPPER_BIT_O,
	output logic CELL_UPPER_PROG_O,
	input wire logic [7:0] CELL_UPPER_RDATA_I,
	// lower macrocell bank
	output logic [opbc_pkg::WADDR_W:0] CELL_LOWER_ADDR_O,
	output logic [2:0] CELL_LOWER_BIT_O,
	output logic CELL_LOWER_PROG_O,
	input wire logic [7:0] CELL_LOWER_RDATA_I,
	// current operating mode, for the rest of the controller
	output logic [2:0] MODE_O
);
	import opbc_pkg::*;

	// whole state of the block, apart from the two bank sequencers
	typedef struct packed {
		opbc_mode_t mode; // operating mode
		logic fast; // fast program timing
		logic en_u; // upper_bank_prog_enable
		logic tgt_u; // upper_bank_target_value
		logic en_l; // lower_bank_prog_enable
		logic tgt_l; // lower_bank_target_value
		logic bsel_u; // upper_byte_select
		logic [2:0] pos_u; // upper_bit_position
		logic bsel_l; // lower_byte_select
		logic [2:0] pos_l; // lower_bit_position
		logic [WADDR_W-1:0] waddr; // program_word_address
		logic start; // one-cycle request to both banks
		logic [7:0] sync1_u; // readback synchroniser, stage one
		logic [7:0] sync2_u; // readback synchroniser, stage two
		logic [7:0] sync1_l;
		logic [7:0] sync2_l;
		logic [WADDR_W-1:0] words; // words_remaining snapshot
		logic [FIFO_CNT_W-1:0] fifo; // fifo_word_count snapshot
		logic terr_u; // upper_test_error
		logic terr_l; // lower_test_error
		logic terr; // test_error_summary
		logic tready; // test mode idle
		logic [31:0] rdata; // read answer
	} opbc_top_st_t;

	opbc_top_st_t cur_ff; // registered state
	opbc_top_st_t nxt_cur; // next state

	logic [1:0] bank_busy; // index 1 upper, 0 lower
	logic [1:0] bank_err;
	logic [1:0] bank_prog;
	logic [1:0] bank_bit; // synchronised cell bit at the selected position
	logic prog_ready; // no bank sequencer running
	logic prog_error_summary;

	// exact word address match, used by every decode
	function automatic logic hit(input logic [31:0] a,
		input logic [31:0] off);
		hit = (a == off);
	endfunction

	// pick one bit of a byte by its position
	function automatic logic pick_bit(input logic [7:0] b,
		input logic [2:0] pos);
		pick_bit = b[pos];
	endfunction

	// bit program control as software reads it back
	function automatic logic [31:0] pctrl_word(input opbc_top_st_t s);
		logic [31:0] w;
		w = 32'h0000_0000; // reserved bits read zero
		w[PC_EN_U_BIT] = s.en_u;
		w[PC_TGT_U_BIT] = s.tgt_u;
		w[PC_EN_L_BIT] = s.en_l;
		w[PC_TGT_L_BIT] = s.tgt_l;
		w[PC_BSEL_U_BIT] = s.bsel_u;
		w[PC_POS_U_LSB +: 3] = s.pos_u;
		w[PC_BSEL_L_BIT] = s.bsel_l;
		w[PC_POS_L_LSB +: 3] = s.pos_l;
		w[PC_WADDR_LSB +: WADDR_W] = s.waddr;
		pctrl_word = w;
	endfunction

	// a mode change must pass through standby
	function automatic logic mode_move_ok(input opbc_mode_t from,
		input logic [2:0] to);
		mode_move_ok = (from == standby_mode) ||
			(to == 3'(standby_mode));
	endfunction

	assign prog_ready = ~|bank_busy;
	assign prog_error_summary = |bank_err;

	// register writes, start of a request, snapshots and read answer
	always_comb begin
		logic [31:0] st;
		st = STATUS_RESET;
		nxt_cur = cur_ff;
		nxt_cur.start = 1'b0;

		// readback passes two flip-flops before any logic sees it
		nxt_cur.sync1_u = CELL_UPPER_RDATA_I;
		nxt_cur.sync2_u = cur_ff.sync1_u;
		nxt_cur.sync1_l = CELL_LOWER_RDATA_I;
		nxt_cur.sync2_l = cur_ff.sync1_l;

		// same-clock status inputs, held in flops so they reset to zero, test ready to one
		nxt_cur.words = WORDS_REMAINING_I;
		nxt_cur.fifo = FIFO_WORD_COUNT_I;
		nxt_cur.terr_u = TEST_ERR_UPPER_I;
		nxt_cur.terr_l = TEST_ERR_LOWER_I;
		nxt_cur.terr = TEST_ERROR_SUMMARY_I;
		nxt_cur.tready = TEST_READY_I;

		if (REG_WR_I) begin
			if (hit(REG_ADDR_I, MODE_OFFSET)) begin
				// a move between two active modes is refused,
				// and no mode change while a bit is being burnt
				if (prog_ready && mode_move_ok(cur_ff.mode,
					REG_WDATA_I[MODE_FIELD_LSB +: 3])) begin
					nxt_cur.mode =
						opbc_mode_t'(REG_WDATA_I[MODE_FIELD_LSB +: 3]);
					nxt_cur.fast = REG_WDATA_I[MODE_FAST_BIT];
				end
			end else if (hit(REG_ADDR_I, PCTRL_OFFSET)) begin
				// fields are frozen while a request is in flight so the
				// cell address cannot move under a program pulse
				if (prog_ready && !cur_ff.start) begin
					nxt_cur.en_u = REG_WDATA_I[PC_EN_U_BIT];
					nxt_cur.tgt_u = REG_WDATA_I[PC_TGT_U_BIT];
					nxt_cur.en_l = REG_WDATA_I[PC_EN_L_BIT];
					nxt_cur.tgt_l = REG_WDATA_I[PC_TGT_L_BIT];
					nxt_cur.bsel_u = REG_WDATA_I[PC_BSEL_U_BIT];
					nxt_cur.pos_u = REG_WDATA_I[PC_POS_U_LSB +: 3];
					nxt_cur.bsel_l = REG_WDATA_I[PC_BSEL_L_BIT];
					nxt_cur.pos_l = REG_WDATA_I[PC_POS_L_LSB +: 3];
					nxt_cur.waddr =
						REG_WDATA_I[PC_WADDR_LSB +: WADDR_W];
					// only manual program mode turns a write into a burn
					nxt_cur.start =
						(cur_ff.mode == manual_program_mode);
				end
			end
			// other addresses and the status word take no write
		end

		// status word assembly
		st[ST_WORDS_LSB +: WADDR_W] = cur_ff.words;
		st[ST_TERR_U_BIT] = cur_ff.terr_u;
		st[ST_TERR_L_BIT] = cur_ff.terr_l;
		st[ST_PERR_U_BIT] = bank_err[1];
		st[ST_PERR_L_BIT] = bank_err[0];
		st[ST_FIFO_LSB +: FIFO_CNT_W] = cur_ff.fifo;
		st[ST_AUTO_RDY_BIT] = 1'b1; // automatic modes live elsewhere
		st[ST_TERR_BIT] = cur_ff.terr;
		st[ST_TRDY_BIT] = cur_ff.tready;
		// the request flop counts as busy so ready never glitches high
		st[ST_PRDY_BIT] = prog_ready & ~cur_ff.start;
		st[ST_PERR_BIT] = prog_error_summary;

		// read answer stands only in the cycle after the strobe
		nxt_cur.rdata = RDATA_RESET;
		if (REG_RD_I) begin
			if (hit(REG_ADDR_I, MODE_OFFSET)) begin
				nxt_cur.rdata[MODE_FIELD_LSB +: 3] = cur_ff.mode;
				nxt_cur.rdata[MODE_FAST_BIT] = cur_ff.fast;
			end else if (hit(REG_ADDR_I, PCTRL_OFFSET)) begin
				nxt_cur.rdata = pctrl_word(cur_ff);
			end else if (hit(REG_ADDR_I, STATUS_OFFSET)) begin
				nxt_cur.rdata = st; // bits 31:29 and 7:5 stay zero
			end else begin
				// unmapped address answers zero
				nxt_cur.rdata = RDATA_RESET;
			end
		end
	end

	// state register
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			cur_ff <= '{mode: standby_mode, fast: 1'b0,
				en_u: 1'b0, tgt_u: 1'b0, en_l: 1'b0, tgt_l: 1'b0,
				bsel_u: 1'b0, pos_u: 3'h0, bsel_l: 1'b0, pos_l: 3'h0,
				waddr: '0, start: 1'b0,
				sync1_u: 8'h00, sync2_u: 8'h00,
				sync1_l: 8'h00, sync2_l: 8'h00,
				words: '0, fifo: '0,
				terr_u: 1'b0, terr_l: 1'b0, terr: 1'b0, tready: 1'b1,
				rdata: RDATA_RESET};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// one sequencer per bank; both start on the same request
	for (genvar b = 0; b < 2; b++) begin : g_bank
		// the selected bit is read from the second sync stage only
		assign bank_bit[b] = (b == 1)
			? pick_bit(cur_ff.sync2_u, cur_ff.pos_u)
			: pick_bit(cur_ff.sync2_l, cur_ff.pos_l);

		opbc_bank_prog #(
			.PULSE_CYC(PULSE_CYCLES),
			.PULSE_FAST_CYC(PULSE_FAST_CYCLES),
			.SETTLE_CYC(SETTLE_CYCLES)
		) u_bank (
			.clk_i(CLK_I),
			.rst_i(SYS_RST_I),
			.start_i(cur_ff.start),
			.enable_i((b == 1) ? cur_ff.en_u : cur_ff.en_l),
			.target_i((b == 1) ? cur_ff.tgt_u : cur_ff.tgt_l),
			.fast_i(cur_ff.fast),
			.cell_bit_i(bank_bit[b]),
			.busy_o(bank_busy[b]),
			.error_o(bank_err[b]),
			.prog_o(bank_prog[b])
		);
	end

	// cell address: word address then byte select, so byte 1 is odd
	assign CELL_UPPER_ADDR_O = {cur_ff.waddr, cur_ff.bsel_u};
	assign CELL_LOWER_ADDR_O = {cur_ff.waddr, cur_ff.bsel_l};
	assign CELL_UPPER_BIT_O = cur_ff.pos_u;
	assign CELL_LOWER_BIT_O = cur_ff.pos_l;
	assign CELL_UPPER_PROG_O = bank_prog[1];
	assign CELL_LOWER_PROG_O = bank_prog[0];
	assign REG_RDATA_O = cur_ff.rdata;
	assign MODE_O = cur_ff.mode;

endmodule

// ==== shared/opbc_pkg.sv ====
package opbc_pkg;

	// clock and derived timing
	localparam int unsigned CLK_PERIOD_NS = 25;
	// least width of a program pulse, normal and fast timing
	localparam int unsigned PROG_PULSE_NS = 10000;
	localparam int unsigned PROG_PULSE_FAST_NS = 5000;
	// least settle time before a verify read is trusted
	localparam int unsigned READ_SETTLE_NS = 100;
	// least times round up to whole cycles
	localparam int unsigned PULSE_CYCLES =
		(PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PULSE_FAST_CYCLES =
		(PROG_PULSE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// two synchroniser stages are added on top of the settle time
	localparam int unsigned SETTLE_CYCLES =
		(READ_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
	localparam int unsigned CNT_W = 16;

	// register byte addresses
	localparam logic [31:0] MODE_OFFSET = 32'h4000_8000;
	localparam logic [31:0] PCTRL_OFFSET = 32'h4000_8004;
	localparam logic [31:0] STATUS_OFFSET = 32'h4000_8008;

	// reset values
	localparam logic [31:0] PCTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// mode register fields
	localparam int unsigned MODE_FIELD_LSB = 0;
	localparam int unsigned MODE_FAST_BIT = 8;

	// bit program control fields
	localparam int unsigned PC_EN_U_BIT = 27;
	localparam int unsigned PC_TGT_U_BIT = 26;
	localparam int unsigned PC_EN_L_BIT = 25;
	localparam int unsigned PC_TGT_L_BIT = 24;
	localparam int unsigned PC_BSEL_U_BIT = 23;
	localparam int unsigned PC_POS_U_LSB = 20;
	localparam int unsigned PC_BSEL_L_BIT = 19;
	localparam int unsigned PC_POS_L_LSB = 16;
	localparam int unsigned PC_WADDR_LSB = 0;
	localparam int unsigned WADDR_W = 13;

	// status fields
	localparam int unsigned ST_WORDS_LSB = 16;
	localparam int unsigned ST_TERR_U_BIT = 15;
	localparam int unsigned ST_TERR_L_BIT = 14;
	localparam int unsigned ST_PERR_U_BIT = 13;
	localparam int unsigned ST_PERR_L_BIT = 12;
	localparam int unsigned ST_FIFO_LSB = 8;
	localparam int unsigned ST_AUTO_RDY_BIT = 4;
	localparam int unsigned ST_TERR_BIT = 3;
	localparam int unsigned ST_TRDY_BIT = 2;
	localparam int unsigned ST_PERR_BIT = 1;
	localparam int unsigned ST_PRDY_BIT = 0;
	localparam int unsigned FIFO_CNT_W = 4;

	// operating modes
	typedef enum logic [2:0] {
		standby_mode = 3'h0,
		manual_read_mode = 3'h1,
		manual_program_mode = 3'h2,
		auto_read_mode = 3'h3,
		auto_program_mode = 3'h4,
		test_mode_a = 3'h5,
		test_mode_b = 3'h6,
		test_mode_c = 3'h7
	} opbc_mode_t;

	// bank sequencer states, one-hot
	typedef enum logic [3:0] {
		BK_IDLE = 4'h1,
		BK_PULSE = 4'h2,
		BK_SETTLE = 4'h4,
		BK_CHECK = 4'h8
	} opbc_bank_state_t;

endpackage

// ==== sim/opbc_bitprog_checker.sv ====
// watches the bit program block at its own ports
module opbc_bitprog_checker (
	// clock and reset
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// register port
	input wire logic [31:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [31:0] REG_RDATA_O,
	// reported state
	input wire logic [opbc_pkg::WADDR_W-1:0] WORDS_REMAINING_I,
	input wire logic [opbc_pkg::FIFO_CNT_W-1:0] FIFO_WORD_COUNT_I,
	// macrocell side
	input wire logic [opbc_pkg::WADDR_W:0] CELL_UPPER_ADDR_O,
	input wire logic [2:0] CELL_UPPER_BIT_O,
	input wire logic CELL_UPPER_PROG_O,
	input wire logic [opbc_pkg::WADDR_W:0] CELL_LOWER_ADDR_O,
	input wire logic [2:0] CELL_LOWER_BIT_O,
	input wire logic CELL_LOWER_PROG_O,
	input wire logic [2:0] MODE_O
);
	timeunit 1ns;
	timeprecision 100ps;
	import opbc_pkg::*;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// length of the running upper pulse, cleared while the pulse is low
	logic [9:0] pulse_cnt_ff;
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I || !CELL_UPPER_PROG_O) pulse_cnt_ff <= 10'h0;
		else pulse_cnt_ff <= pulse_cnt_ff + 10'h1;
	end
	// cell address and bit must not move during the first 8 cycles of a burning pulse
	sequence s_up_hold;
		(CELL_UPPER_PROG_O && $stable(CELL_UPPER_ADDR_O) &&
			$stable(CELL_UPPER_BIT_O)) [*8];
	endsequence
	a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
		else $error("read data not zero outside a read answer");
	a_status_rsvd: assert property ($past(REG_RD_I &&
		REG_ADDR_I == STATUS_OFFSET) |-> REG_RDATA_O[31:29] == 3'h0 &&
		REG_RDATA_O[7:5] == 3'h0) else $error("status spare bits set");
	a_status_counts: assert property ($past(REG_RD_I &&
		REG_ADDR_I == STATUS_OFFSET) |->
		REG_RDATA_O[28:16] == $past(WORDS_REMAINING_I, 2) &&
		REG_RDATA_O[11:8] == $past(FIFO_WORD_COUNT_I, 2))
		else $error("status counts wrong");
	a_prog_mode: assert property (CELL_UPPER_PROG_O || CELL_LOWER_PROG_O
		|-> MODE_O == manual_program_mode) else $error("pulse outside mode");
	a_upper_start: assert property ($rose(CELL_UPPER_PROG_O) |->
		$past(REG_WR_I && REG_ADDR_I == PCTRL_OFFSET &&
		REG_WDATA_I[27] && REG_WDATA_I[26], 2))
		else $error("upper pulse without enabled write");
	a_lower_start: assert property ($rose(CELL_LOWER_PROG_O) |->
		$past(REG_WR_I && REG_ADDR_I == PCTRL_OFFSET &&
		REG_WDATA_I[25] && REG_WDATA_I[24], 2))
		else $error("lower pulse without enabled write");
	a_upper_map: assert property ($rose(CELL_UPPER_PROG_O) |->
		CELL_UPPER_ADDR_O == {$past(REG_WDATA_I[12:0], 2),
		$past(REG_WDATA_I[23], 2)} &&
		CELL_UPPER_BIT_O == $past(REG_WDATA_I[22:20], 2))
		else $error("upper cell address wrong");
	a_lower_map: assert property ($rose(CELL_LOWER_PROG_O) |->
		CELL_LOWER_ADDR_O == {$past(REG_WDATA_I[12:0], 2),
		$past(REG_WDATA_I[19], 2)} &&
		CELL_LOWER_BIT_O == $past(REG_WDATA_I[18:16], 2))
		else $error("lower cell address wrong");
	a_upper_hold: assert property ($rose(CELL_UPPER_PROG_O) |-> s_up_hold)
		else $error("upper pulse short or cell moved");
	a_pulse_len: assert property ($fell(CELL_UPPER_PROG_O) |->
		pulse_cnt_ff == 10'(PULSE_CYCLES) ||
		pulse_cnt_ff == 10'(PULSE_FAST_CYCLES))
		else $error("upper pulse length wrong");
endmodule

// ==== sim/opbc_cell_model.sv ====
// one 8-bit macrocell bank; a pulse burns the addressed bit to 1
module opbc_cell_model (
	// clock
	input wire logic clk_i,
	// cell access, byte select is the address lsb
	input wire logic [opbc_pkg::WADDR_W:0] addr_i,
	input wire logic [2:0] bit_i,
	input wire logic prog_i,
	// fault injection: pulses leave the cell unburnt
	input wire logic fail_i,
	// byte readback, always driven by the cells
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import opbc_pkg::*;
	// two bytes of the bank per word, blank cells read 0
	bit [7:0] mem [0:(1 << (WADDR_W + 1)) - 1];
	// burning only ever sets a bit, as a real fuse does
	always @(posedge clk_i) begin
		if (prog_i && !fail_i) mem[addr_i][bit_i] <= 1'b1;
	end
	assign rdata_o = mem[addr_i];
endmodule

// ==== sim/tb.sv ====
// register level bench with two cell bank models
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import opbc_pkg::*;
	typedef struct {logic [31:0] d; logic [31:0] m;} opbc_exp_t;
	localparam logic [31:0] CTRL_MASK = 32'h0fff_1fff;
	logic clk = 0, rst = 1, wr = 0, rd = 0, chk = 0;
	logic [31:0] addr = 0, wdata = 0, rdata;
	logic [12:0] words = 0;
	logic [3:0] fifo = 0;
	logic teu = 0, tel = 0, tes = 0, trd = 1, fu = 0, fl = 0;
	logic [13:0] cua, cla;
	logic [2:0] cub, clb, mode;
	logic cup, clp;
	logic [7:0] cur, clr;
	int seed, err_count = 0, n_tests = 0;
	// shadow of burnt cells, kept apart from the models
	bit [7:0] shu [0:16383];
	bit [7:0] shl [0:16383];
	opbc_exp_t q[$];
	opbc_bitprog opbc_bitprog_i (.CLK_I(clk), .SYS_RST_I(rst),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_RDATA_O(rdata), .WORDS_REMAINING_I(words),
		.FIFO_WORD_COUNT_I(fifo), .TEST_ERR_UPPER_I(teu),
		.TEST_ERR_LOWER_I(tel), .TEST_ERROR_SUMMARY_I(tes),
		.TEST_READY_I(trd), .CELL_UPPER_ADDR_O(cua), .CELL_UPPER_BIT_O(cub),
		.CELL_UPPER_PROG_O(cup), .CELL_UPPER_RDATA_I(cur),
		.CELL_LOWER_ADDR_O(cla), .CELL_LOWER_BIT_O(clb),
		.CELL_LOWER_PROG_O(clp), .CELL_LOWER_RDATA_I(clr), .MODE_O(mode));
	opbc_cell_model opbc_cell_model_u_i (.clk_i(clk), .addr_i(cua),
		.bit_i(cub), .prog_i(cup), .fail_i(fu), .rdata_o(cur));
	opbc_cell_model opbc_cell_model_l_i (.clk_i(clk), .addr_i(cla),
		.bit_i(clb), .prog_i(clp), .fail_i(fl), .rdata_o(clr));
	// 40 MHz
	always #12.5 clk = ~clk;
	// expected status word from the current input levels
	function automatic logic [31:0] st(input logic pu, input logic pl);
		st = {3'h0, words, teu, tel, pu, pl, fifo, 3'h0, 1'b1, tes, trd,
			pu | pl, 1'b1};
	endfunction
	// one bus cycle; a read notes its expectation, mask marks checked bits
	task automatic bus(input logic w, input logic [31:0] a, d, m);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		if (!w) q.push_back('{d, m});
		@(posedge clk);
	endtask
	// drop both strobes for one cycle
	task automatic idle();
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cmp(input logic [31:0] got, input opbc_exp_t e);
		n_tests++;
		if ((got & e.m) !== (e.d & e.m)) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time,
				got & e.m, e.d & e.m);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (chk && q.size() > 0) cmp(rdata, q.pop_front());
		chk <= rd;
	end
	// a hung run counts as a failure
	initial begin
		#(25 * 20000);
		err_count++;
		conclude();
	end
	initial begin
		logic [31:0] r, d;
		logic pu, pl, f;
		logic [13:0] ku, kl;
		seed = 60930;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(0, PCTRL_OFFSET, PCTRL_RESET, '1);
		bus(0, STATUS_OFFSET, st(0, 0), '1);
		bus(1, STATUS_OFFSET, '1, 0);
		bus(0, STATUS_OFFSET, st(0, 0), '1);
		bus(0, 32'h4000_8020, 0, '1);
		d = $random(seed);
		bus(1, PCTRL_OFFSET, d, 0);
		bus(0, PCTRL_OFFSET, d & CTRL_MASK, '1);
		idle();
		$display("register access test done");
		for (int i = 0; i < 12; i++) begin
			f = (i >= 6);
			if (i % 6 == 0) begin
				bus(1, MODE_OFFSET, 0, 0);
				bus(1, MODE_OFFSET, {23'h0, f, 8'h02}, 0);
				bus(1, MODE_OFFSET, 32'h3, 0);
				bus(0, MODE_OFFSET, {23'h0, f, 8'h02}, '1);
			end
			r = $random(seed);
			{trd, tes, tel, teu, fifo, words} <= r[20:0];
			fu <= r[31];
			fl <= r[30];
			// few words so that targets of 0 meet burnt cells
			d = $random(seed) & CTRL_MASK;
			d[12:2] = 11'h0;
			d[27] = i[0];
			d[25] = i[1];
			ku = {d[12:0], d[23]};
			kl = {d[12:0], d[19]};
			pu = d[27] && (d[26] ? r[31] : shu[ku][d[22:20]]);
			pl = d[25] && (d[24] ? r[30] : shl[kl][d[18:16]]);
			if (d[27] && d[26] && !r[31]) shu[ku][d[22:20]] = 1'b1;
			if (d[25] && d[24] && !r[30]) shl[kl][d[18:16]] = 1'b1;
			bus(1, PCTRL_OFFSET, d, 0);
			bus(0, STATUS_OFFSET, 0, 1);
			// with no bank enabled the block is idle again at once, so a
			// second write would be taken and start an unplanned burn
			if (d[27] || d[25]) bus(1, PCTRL_OFFSET, ~d, 0);
			else idle();
			idle();
			repeat (410) @(posedge clk);
			bus(0, PCTRL_OFFSET, d, CTRL_MASK);
			bus(0, STATUS_OFFSET, st(pu, pl), '1);
			idle();
			$display("program request %0d done", i);
		end
		bus(1, MODE_OFFSET, 0, 0);
		bus(0, MODE_OFFSET, 0, '1);
		idle();
		idle();
		conclude();
	end
endmodule
bind opbc_bitprog opbc_bitprog_checker opbc_bitprog_checker_i (.*);
